//--- design/flash_cmd.sv
`timescale 1ns/10ps
// Operation
// [R1] opcodes 60h and c7h erase whole array
// [R2] finished erase fills array with ffh
// [R3] erase ignored while any block protected
// [R4] erase starts at select rise, self-timed
// [R5] erase needs the write latch set
// [R6] write enable sets the write latch
// [R7] single-byte commands act at select rise
// [R8] status read answered at any time
// [R9] status repeats until select rises
// [R10] status write clears the write latch
// [R11] write disable clears latch and auto-increment
// [R12] write disable leaves running program alone
// [R13] arm command must precede status write; code also accepts it while the write latch is set
// [R14] status write changes protect and lock only
// [R15] locked and protect pin low: ignore write
// [R16] protect pin low: lock only sets
// [R17] protect pin high: all protect bits free
// [R18] conditions checked at select rise
// [R19] standard id: maker, type, capacity bytes
// [R20] select rise stops id output at once
// [R21] legacy id: 90h/abh plus 24-bit address
// [R22] legacy id alternates maker and device
// [R23] 04h is write disable, 05h status read
// [R24] sample on sck rise, drive on fall
module flash_cmd
  import flash_cmd_pkg::*;
#(
  parameter logic [7:0] MFR_ID = 8'h5a,    // arbitrary value
  parameter logic [7:0] MEM_TYPE = 8'h3c,  // arbitrary value
  parameter logic [7:0] CAPACITY = 8'h17,  // arbitrary value
  parameter logic [7:0] DEV_CODE = 8'h17,  // arbitrary value
  parameter int ERASE_CYCLE_COUNT = ERASE_CYCLES
) (
  // system
  input wire logic clock,
  input wire logic rst,
  // serial link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  input wire logic wp_n,
  // array side
  input wire logic program_active,
  output logic erase_busy,
  output logic erase_done,
  output logic [7:0] erase_fill,
  // status view
  output logic [7:0] status_byte,
  output logic write_latch_bit,
  output logic auto_increment_flag,
  output logic protect_lock_bit,
  output logic [3:0] block_protect
);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [5:0] header_bits(input logic [7:0] op);
    case (op)
      OP_STATUS_READ, OP_JEDEC_ID: header_bits = OPCODE_BITS;
      OP_LEGACY_ID_A, OP_LEGACY_ID_B: header_bits = LEGACY_HDR_BITS;
      default: header_bits = NO_OUTPUT_BITS;
    endcase
  endfunction

  function automatic logic is_legacy(input logic [7:0] op);
    is_legacy = (op == OP_LEGACY_ID_A) || (op == OP_LEGACY_ID_B);
  endfunction

  frame_t f_q, f_d;
  cmd_t c_q, c_d;
  drive_t d_q, d_d;
  sys_t s_q, s_d;
  logic frame_rst;
  logic [7:0] bits_in;
  logic [7:0] out_sel;
  logic in_data;

  // a raised select ends the frame without any further sck edge
  assign frame_rst = rst | cs_n;
  assign bits_in = {f_q.shift, si};
  assign in_data = (f_q.cnt >= OPCODE_BITS) && (f_q.cnt >= header_bits(c_q.opcode));

  // ************************************************************
  // link side: shift in on rising sck
  // ************************************************************
  always_comb begin
    f_d = f_q;
    c_d = c_q;
    if (f_q.cnt != NO_OUTPUT_BITS) begin
      f_d.cnt = f_q.cnt + 6'h01;
    end
    f_d.shift = bits_in[6:0]; // R24
    c_d.len = f_d.cnt;
    // status crosses as independent flags through two stages
    c_d.st_m = status_byte;
    c_d.st_s = c_q.st_m;
    if (f_q.cnt == 6'h07) begin
      c_d.opcode = bits_in; // R24
    end
    if (f_q.cnt == 6'h0f) begin
      c_d.data = bits_in;
    end
    if (f_q.cnt == 6'h1f) begin
      f_d.out_byte = {1'b0, si}; // R21
    end
    if (in_data) begin
      f_d.out_bit = f_q.out_bit + 3'h1;
      if (f_q.out_bit == 3'h7) begin
        if (is_legacy(c_q.opcode)) begin
          f_d.out_byte = {1'b0, ~f_q.out_byte[0]}; // R22
        end else if (f_q.out_byte != 2'h3) begin
          f_d.out_byte = f_q.out_byte + 2'h1; // R19
        end
      end
    end
  end

  always_ff @(posedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end

  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      c_q <= '0;
    end else begin
      c_q <= c_d;
    end
  end

  // ************************************************************
  // link side: drive out on falling sck
  // ************************************************************
  always_comb begin
    d_d = '0;
    out_sel = 8'h00;
    case (c_q.opcode)
      OP_STATUS_READ: begin
        out_sel = c_q.st_s; // R8 R9
      end
      OP_JEDEC_ID: begin
        // after the three id bytes the line reads as zero
        case (f_q.out_byte)
          2'h0: out_sel = MFR_ID; // R19
          2'h1: out_sel = MEM_TYPE;
          2'h2: out_sel = CAPACITY;
          default: out_sel = 8'h00;
        endcase
      end
      OP_LEGACY_ID_A, OP_LEGACY_ID_B: begin
        if (f_q.out_byte[0]) begin
          out_sel = DEV_CODE; // R21 R22
        end else begin
          out_sel = MFR_ID; // R21
        end
      end
      default: begin
        out_sel = 8'h00;
      end
    endcase
    d_d.oe = in_data && (header_bits(c_q.opcode) != NO_OUTPUT_BITS);
    d_d.so = out_sel[~f_q.out_bit]; // R24
  end

  always_ff @(negedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      d_q <= '0; // R20
    end else begin
      d_q <= d_d;
    end
  end

  assign so = d_q.so;
  assign so_oe = d_q.oe;

  // ************************************************************
  // system side: decode helpers
  // ************************************************************
  // an opcode-only frame counts only after exactly eight bits, so a frame
  // cut after one to seven bits or overlong never acts; one with no sck edge re-decodes the previous opcode and length
  function automatic logic len_exact(input logic [5:0] len);
    len_exact = (len == OPCODE_BITS);
  endfunction

  // a status write needs the whole data byte behind the opcode
  function automatic logic len_status(input logic [5:0] len);
    len_status = (len >= STATUS_WRITE_BITS);
  endfunction

  // with the pin low the lock may only be set, never released
  function automatic logic lock_next(
    input logic pin_high,
    input logic lock_now,
    input logic lock_req
  );
    if (pin_high) begin
      lock_next = lock_req; // R17
    end else begin
      lock_next = lock_now | lock_req; // R16
    end
  endfunction

  // ************************************************************
  // system side: select edge and protection view
  // ************************************************************
  logic cs_rise;
  logic busy;
  logic st_write_ok;
  logic wp_high;
  logic protect_clear;
  logic do_write_enable;
  logic do_write_disable;
  logic do_status_arm;
  logic do_status_write;
  logic do_erase;

  // frame registers are quiet once select is high, so reading them
  // after the synchronised rise is safe
  assign cs_rise = s_q.cs_s & ~s_q.cs_d; // R7 R18
  assign wp_high = s_q.wp_s;
  assign busy = (s_q.state != ST_IDLE) | program_active; // R12
  assign protect_clear = (s_q.bp == 4'h0); // R3
  // R15 R16 R17
  assign st_write_ok = (s_q.armed | s_q.wr_latch) & ~(~wp_high & s_q.lock);

  // ************************************************************
  // system side: command decode at select rise
  // ************************************************************
  // busy refuses every write-type command; write disable still acts
  // unknown opcodes decode to nothing at all
  always_comb begin
    do_write_enable = 1'b0;
    do_write_disable = 1'b0;
    do_status_arm = 1'b0;
    do_status_write = 1'b0;
    do_erase = 1'b0;
    if (cs_rise) begin
      case (c_q.opcode)
        OP_WRITE_ENABLE: begin
          do_write_enable = len_exact(c_q.len) && !busy; // R6 R7
        end
        OP_WRITE_DISABLE: begin
          do_write_disable = len_exact(c_q.len); // R23
        end
        OP_STATUS_ARM: begin
          do_status_arm = len_exact(c_q.len) && !busy; // R13
        end
        OP_STATUS_WRITE: begin
          do_status_write = len_status(c_q.len) && !busy; // R14
        end
        OP_ERASE_A, OP_ERASE_B: begin
          do_erase = len_exact(c_q.len) && !busy; // R1 R4
        end
        default: begin
        end
      endcase
    end
  end

  // ************************************************************
  // system side: command execution
  // ************************************************************
  always_comb begin
    s_d = s_q;
    s_d.cs_m = cs_n;
    s_d.cs_s = s_q.cs_m;
    s_d.cs_d = s_q.cs_s;
    s_d.wp_m = wp_n;
    s_d.wp_s = s_q.wp_m;
    s_d.erase_done = 1'b0;

    // any frame but the arm itself disarms, so with the write latch clear the status write
    // must come directly after it
    if (cs_rise) begin
      s_d.armed = 1'b0; // R13
    end
    if (do_status_arm) begin
      s_d.armed = 1'b1; // R13
    end

    if (do_write_enable) begin
      s_d.wr_latch = 1'b1; // R6
    end
    if (do_write_disable) begin
      // a program already running is left to finish
      s_d.wr_latch = 1'b0; // R11
      s_d.auto_inc = 1'b0; // R11
    end

    if (do_status_write) begin
      if (st_write_ok) begin
        s_d.bp = c_q.data[ST_BP_HI:ST_BP_LO]; // R14 R18
        s_d.lock = lock_next(wp_high, s_q.lock, c_q.data[ST_LOCK]); // R16
      end
      // the latch drops even when the write itself is refused
      s_d.wr_latch = 1'b0; // R10
    end

    // the erase needs the latch and uses it up
    if (do_erase && s_q.wr_latch && protect_clear) begin
      s_d.state = ST_ERASING; // R3 R5
      s_d.timer = '0;
      s_d.wr_latch = 1'b0;
    end

    // ************************************************************
    // erase timer
    // ************************************************************
    case (s_q.state)
      ST_IDLE: begin
      end
      ST_ERASING: begin
        s_d.timer = s_q.timer + 32'h1;
        if (s_q.timer == 32'(ERASE_CYCLE_COUNT - 1)) begin
          s_d.state = ST_DONE; // R4
        end
      end
      ST_DONE: begin
        s_d.fill = ERASED_BYTE; // R2
        s_d.erase_done = 1'b1;
        s_d.state = ST_IDLE;
      end
      default: s_d.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.cs_m <= 1'b1;
      s_q.cs_s <= 1'b1;
      s_q.cs_d <= 1'b1;
      s_q.wp_m <= 1'b1;
      s_q.wp_s <= 1'b1;
      s_q.bp <= BP_RESET;
      s_q.lock <= LOCK_RESET;
      s_q.state <= ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // status view
  // ************************************************************
  always_comb begin
    status_byte = 8'h00;
    status_byte[ST_BUSY] = busy; // R8
    status_byte[ST_WR_LATCH] = s_q.wr_latch;
    status_byte[ST_BP_HI:ST_BP_LO] = s_q.bp;
    status_byte[ST_AUTO_INC] = s_q.auto_inc;
    status_byte[ST_LOCK] = s_q.lock;
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign erase_busy = (s_q.state != ST_IDLE);
  assign erase_done = s_q.erase_done;
  assign erase_fill = s_q.fill;
  assign write_latch_bit = s_q.wr_latch;
  assign auto_increment_flag = s_q.auto_inc;
  assign protect_lock_bit = s_q.lock;
  assign block_protect = s_q.bp;

endmodule

//--- design/flash_cmd_pkg.sv
package flash_cmd_pkg;

  // opcodes
  localparam logic [7:0] OP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_ERASE_B = 8'hc7;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_STATUS_ARM = 8'h50;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_JEDEC_ID = 8'h9f;
  localparam logic [7:0] OP_LEGACY_ID_A = 8'h90;
  localparam logic [7:0] OP_LEGACY_ID_B = 8'hab;

  // frame lengths in bits
  localparam logic [5:0] OPCODE_BITS = 6'h08;
  localparam logic [5:0] STATUS_WRITE_BITS = 6'h10;
  localparam logic [5:0] LEGACY_HDR_BITS = 6'h20;
  localparam logic [5:0] NO_OUTPUT_BITS = 6'h3f;

  // status byte layout
  localparam int ST_BUSY = 0;
  localparam int ST_WR_LATCH = 1;
  localparam int ST_BP_LO = 2;
  localparam int ST_BP_HI = 5;
  localparam int ST_AUTO_INC = 6;
  localparam int ST_LOCK = 7;

  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [3:0] BP_RESET = 4'hf;
  localparam logic LOCK_RESET = 1'b0;

  // full-array erase time
  localparam int ERASE_TIME_US = 50000;
  localparam int CLOCK_MHZ = 40;
  localparam int ERASE_CYCLES = ERASE_TIME_US * CLOCK_MHZ;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ERASING = 2'b01,
    ST_DONE = 2'b11
  } erase_state_t;

  // link domain, cleared with every frame
  typedef struct packed {
    logic [5:0] cnt;
    logic [6:0] shift;
    logic [2:0] out_bit;
    logic [1:0] out_byte;
  } frame_t;

  // link domain, survives the frame so the system side can read it
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] data;
    logic [5:0] len;
    logic [7:0] st_m;
    logic [7:0] st_s;
  } cmd_t;

  typedef struct packed {
    logic so;
    logic oe;
  } drive_t;

  typedef struct packed {
    logic cs_m;
    logic cs_s;
    logic cs_d;
    logic wp_m;
    logic wp_s;
    logic wr_latch;
    logic auto_inc;
    logic [3:0] bp;
    logic lock;
    logic armed;
    erase_state_t state;
    logic [31:0] timer;
    logic erase_done;
    logic [7:0] fill;
  } sys_t;

endpackage

//--- verif/flash_cmd_properties.sv
`timescale 1ns/10ps
// **********
// erase and status checks
// **********
module flash_cmd_properties #(
  parameter int ERASE_CYCLE_COUNT = 20
) (
  // watched ports
  input wire logic clock,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic so_oe,
  input wire logic wp_n,
  input wire logic erase_busy,
  input wire logic erase_done,
  input wire logic [7:0] erase_fill,
  input wire logic [7:0] status_byte,
  input wire logic write_latch_bit,
  input wire logic auto_increment_flag,
  input wire logic protect_lock_bit,
  input wire logic [3:0] block_protect
);
  localparam int MAXW = ERASE_CYCLE_COUNT + 4;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  status_map_a: assert property (status_byte[7:1] == {protect_lock_bit,
    auto_increment_flag, block_protect, write_latch_bit}) else $error("status view");
  busy_view_a: assert property (erase_busy |-> status_byte[0]) else $error("busy");
  fill_done_a: assert property (erase_done |-> erase_fill == 8'hff) else $error("fill");
  erase_guard_a: assert property ($rose(erase_busy) |->
    $past(write_latch_bit) && block_protect == 4'h0) else $error("erase guard");
  erase_start_a: assert property ($rose(erase_busy) |->
    $past(cs_n) && $past(cs_n, 2)) else $error("erase start");
  erase_time_a: assert property ($rose(erase_busy) |->
    erase_busy [*8] ##[1:MAXW] erase_done) else $error("erase time");
  latch_rise_a: assert property ($rose(write_latch_bit) |->
    cs_n && $past(cs_n)) else $error("latch set");
  oe_release_a: assert property (cs_n && $past(cs_n) |-> !so_oe) else $error("oe");
  lock_hold_a: assert property ($fell(protect_lock_bit) |-> wp_n) else $error("lock");
  lock_freeze_a: assert property (!wp_n && $past(wp_n, 4) == 1'b0 && protect_lock_bit
    |=> $stable(block_protect) && protect_lock_bit) else $error("locked");
endmodule

//--- verif/flash_host.sv
`timescale 1ns/10ps
// **********
// host controller
// **********
module flash_host (
  // link
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // clock stands still outside frames; si toggles once released
  task automatic xfer(input logic [63:0] tx, input int n, output logic [63:0] rx);
    rx = '0;
    cs_n = 1'b0;
    #50;
    for (int i = n - 1; i >= 0; i--) begin
      si = tx[i];
      #31.25;
      sck = 1'b1;
      rx = {rx[62:0], so};
      #62.5;
      sck = 1'b0;
      #31.25;
    end
    #50;
    cs_n = 1'b1;
    si = ~si;
    #200;
  endtask
endmodule

//--- verif/test_flash_cmd.sv
`timescale 1ns/10ps
// **********
// command bench
// **********
module test_flash_cmd;
  import flash_cmd_pkg::*;
  localparam logic [7:0] MFR = 8'h5a; // arbitrary value
  localparam logic [7:0] TYP = 8'h3c; // arbitrary value
  localparam logic [7:0] CAP = 8'h17; // arbitrary value
  localparam logic [7:0] DEV = 8'h2e; // arbitrary value
  logic clock, rst, sck, cs_n, si, so, so_oe, wp_n, program_active, erase_busy, erase_done;
  logic write_latch_bit, auto_increment_flag, protect_lock_bit;
  logic [7:0] erase_fill, status_byte;
  logic [3:0] block_protect;
  logic [63:0] rx;
  int n_fail, tests_run;
  flash_cmd #(.MFR_ID(MFR), .MEM_TYPE(TYP), .CAPACITY(CAP), .DEV_CODE(DEV),
    .ERASE_CYCLE_COUNT(400)) i_flash_cmd (.clock, .rst, .sck, .cs_n, .si, .so, .so_oe,
    .wp_n, .program_active, .erase_busy, .erase_done, .erase_fill, .status_byte,
    .write_latch_bit, .auto_increment_flag, .protect_lock_bit, .block_protect);
  flash_host i_flash_host (.sck, .cs_n, .si, .so);
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic op(input logic [7:0] c);
    i_flash_host.xfer({56'h0, c}, 8, rx);
  endtask
  task automatic status_write(input logic [7:0] d);
    op(OP_STATUS_ARM);
    i_flash_host.xfer({48'h0, OP_STATUS_WRITE, d}, 16, rx);
  endtask
  task automatic status_read;
    i_flash_host.xfer({40'h0, 8'h05, 16'h0}, 24, rx);
  endtask
  task automatic conclude;
    $display("mismatches %0d of %0d", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wait_done;
    for (int t = 0; t < 1000; t++) begin
      @(posedge clock);
      #1;
      if (erase_done === 1'b1) return;
    end
    n_fail++;
    conclude();
  endtask
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    rst = 1'b1;
    wp_n = 1'b1;
    program_active = 1'b0;
    n_fail = 0;
    tests_run = 0;
    repeat (20) @(posedge clock);
    #1 rst = 1'b0;
    repeat (4) @(posedge clock);
    chk(status_byte, 8'h3c);
    status_read();
    chk(rx[15:0], 16'h3c3c);
    i_flash_host.xfer({32'h0, 8'h9f, 24'h0}, 32, rx);
    chk(rx[23:0], {MFR, TYP, CAP});
    for (int a = 0; a < 4; a++) begin
      i_flash_host.xfer({8'h0, a[1] ? 8'hab : 8'h90, 23'h0, a[0], 24'h0}, 56, rx);
      chk(rx[23:0], a[0] ? {DEV, MFR, DEV} : {MFR, DEV, MFR});
    end
    op(8'h60);
    chk(erase_busy, 1'b0);
    op(OP_WRITE_ENABLE);
    chk(write_latch_bit, 1'b1);
    op(8'h04);
    chk(write_latch_bit, 1'b0);
    op(OP_WRITE_ENABLE);
    op(8'hc7);
    chk(erase_busy, 1'b0);
    status_write(8'h08);
    chk(status_byte, 8'h08);
    op(OP_STATUS_ARM);
    status_read();
    i_flash_host.xfer({48'h0, OP_STATUS_WRITE, 8'h00}, 16, rx);
    chk(block_protect, 4'h2);
    @(posedge clock);
    #1 wp_n = 1'b0;
    status_write(8'h80);
    chk(status_byte, 8'h80);
    status_write(8'h3c);
    chk(status_byte, 8'h80);
    @(posedge clock);
    #1 wp_n = 1'b1;
    status_write(8'h00);
    chk(status_byte, 8'h00);
    for (int k = 0; k < 2; k++) begin
      op(OP_WRITE_ENABLE);
      op(k ? 8'hc7 : 8'h60);
      chk(erase_busy, 1'b1);
      status_read();
      chk(rx[0], 1'b1);
      wait_done();
      chk(erase_fill, 8'hff);
    end
    @(posedge clock);
    #1 program_active = 1'b1;
    op(OP_WRITE_ENABLE);
    chk(write_latch_bit, 1'b0);
    status_read();
    chk(rx[0], 1'b1);
    conclude();
  end
endmodule
bind flash_cmd flash_cmd_properties #(.ERASE_CYCLE_COUNT(ERASE_CYCLE_COUNT)) i_props (
  .clock, .rst, .cs_n, .so_oe, .wp_n, .erase_busy, .erase_done, .erase_fill, .status_byte,
  .write_latch_bit, .auto_increment_flag, .protect_lock_bit, .block_protect);
